// ===== rtl/pdw_pkg.sv
/*
  Package for the power-down wake controller: instruction codes, state
  encodings, reset values and grouped signal structs.
  Assumes a core that reports each executed instruction as a one-cycle pulse.
*/
package pdw_pkg;

  localparam int unsigned INSTR_W = 4;

  // Decoded instruction codes seen on the execute port
  localparam logic [3:0] INSTR_NOP        = 4'h0;
  localparam logic [3:0] INSTR_ARM        = 4'h1;
  localparam logic [3:0] INSTR_CLK_HALT   = 4'h2;
  localparam logic [3:0] INSTR_RAM_HALT   = 4'h3;
  localparam logic [3:0] INSTR_SKIP_PDF   = 4'h4;
  localparam logic [3:0] INSTR_SYS_RST    = 4'h5;
  localparam logic [3:0] INSTR_WDT_RST    = 4'h6;
  localparam logic [3:0] INSTR_VDROP_STBY = 4'h7;

  localparam int unsigned SP_W      = 3;
  localparam logic [2:0]  SP_INIT   = 3'h7;
  localparam int unsigned PC_W      = 13;
  localparam logic [12:0] PC_START  = 13'h0000;
  localparam logic [1:0]  SEL_CNTR_IN = 2'h3;

  // Wake settle length; not used, wake is not stretched and the restart strobe lasts one cycle
  localparam int unsigned WAKE_SETTLE = 2;

  typedef enum logic [1:0]
  {
    PDW_RUN      = 2'b00,
    PDW_CLK_KEEP = 2'b01,
    PDW_WAKE     = 2'b11,
    PDW_RAM_KEEP = 2'b10
  } pdw_state_type;

  // Power-domain controls handed to the rest of the chip
  typedef struct packed
  {
    logic sub_osc_run;
    logic lowspd_osc_run;
    logic main_osc_run;
    logic timer3_run;
    logic display_on;
    logic timer1_2_valid;
    logic timer_lc_valid;
    logic vdrop_det_en;
  } pdw_ctrl_type;

  // Initialize strobes for core state on entry
  typedef struct packed
  {
    logic core_regs;
    logic irq_ctrl;
    logic timer_pa_w2;
    logic ext_irq_flag;
    logic irq_enable_flag;
    logic voltage_drop_flag;
    logic watchdog;
  } pdw_init_type;

endpackage

// ===== rtl/pdw_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes an asynchronous input; output changes once stages two and three agree.
*/
`timescale 1ns/10ps
module pdw_sync
#(
  parameter logic RST_VAL = 1'b0
)
(
  input  wire logic core_clk_i,  // Core clock
  input  wire logic nrst_i,      // Async reset, low
  input  wire logic clk_en_i,    // Clock enable
  input  wire logic async_i,     // Raw pin
  output logic      sync_o       // Filtered level
);

  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } pdw_sync_state_type;

  pdw_sync_state_type st_reg;
  pdw_sync_state_type st_next;

  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = async_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3)
    begin
      st_next.out = st_reg.s3;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end
    else if (clk_en_i)
    begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.out;

endmodule

// ===== rtl/pdw_pin_ctrl.sv
/*
  Timer output pin drive during power-down.
  Assumes the core supplies the run-time pin level and enable.
*/
`timescale 1ns/10ps
module pdw_pin_ctrl
  import pdw_pkg::*;
(
  input  wire logic       powered_down_i, // In power-down
  input  wire logic [1:0] cnt_in_sel_i,   // Counter input select
  input  wire logic       run_out_i,      // Core pin level
  input  wire logic       run_oe_i,       // Core pin enable
  output logic            pin_out_o,      // Pin level
  output logic            pin_oe_o        // Pin enable
);

  always_comb
  begin
    if (powered_down_i)
    begin
      pin_out_o = 1'b0;
      pin_oe_o  = (cnt_in_sel_i != SEL_CNTR_IN);
    end
    else
    begin
      pin_out_o = run_out_i;
      pin_oe_o  = run_oe_i;
    end
  end

endmodule

// ===== rtl/pdw_ctrl.sv
/*
  Power-down wake controller: arming, mode entry, entry initialisation,
  power-domain controls, wake and warm/cold start flag.
  Assumes the core pulses instr_valid_i per executed instruction and obeys
  the init and restart strobes; reset sources arrive already decoded.
*/
// Notes on behaviour
// - Arm then first halt gives clock-keep; arm then second halt gives RAM-keep.
// - A halt without prior arming acts as no operation.
// - Clock-keep runs sub oscillator, low-speed oscillator, timer 3, display; RAM-keep stops all.
// - Display on in clock-keep, off in RAM-keep.
// - RAM and listed control registers are retained across power-down.
// - Entry initializes core registers, interrupt controls, prescaler, timer 2, flags.
// - Stack pointer becomes 7 on entry.
// - Timers 1, 2 undefined after power-down; timer LC only in RAM-keep.
// - Timer 3 flag kept through both modes; timer 3 runs only in clock-keep, stopped in RAM-keep.
// - Watchdog function and its flags are initialized on entry.
// - Unlisted state is undefined after power-down; software reloads it.
// - Voltage-drop detection active in power-down only if standby enable executed.
// - Timer pin drives low in power-down, floats when counter input selected.
// - External wakeup or timer 3 underflow causes a warm start.
// - Warm start restarts at address zero and sets power-down flag.
// - Any reset source gives cold start and clears power-down flag.
// - Skip instruction tests the power-down flag.
// - After wake, timer 3 flag one means timer wake, zero key wake.
// - Clock-keep accepts external wakeup or timer 3 flag.
// - RAM-keep accepts only external wakeup.
`timescale 1ns/10ps
module pdw_ctrl
  import pdw_pkg::*;
(
  input  wire logic                 core_clk_i,       // 10 MHz core clock
  input  wire logic                 nrst_i,           // Async reset, low
  input  wire logic                 clk_en_i,         // Clock enable
  input  wire logic                 instr_valid_i,    // Instruction executed
  input  wire logic [INSTR_W-1:0]   instr_code_i,     // Decoded instruction
  input  wire logic                 ext_wake_i,       // External wakeup pin
  input  wire logic                 timer3_irq_flag_i,// Timer 3 flag level
  input  wire logic                 vdrop_pin_en_i,   // Detector enable pin
  input  wire logic                 wdt_reset_i,      // Watchdog reset
  input  wire logic                 por_reset_i,      // Power-on reset
  input  wire logic                 vdrop_reset_i,    // Voltage-drop reset
  input  wire logic [1:0]           cnt_in_sel_i,     // Counter input select
  input  wire logic                 tmr_pin_out_i,    // Core timer pin level
  input  wire logic                 tmr_pin_oe_i,     // Core timer pin enable
  output logic                      powered_down_o,   // Any power-down mode
  output logic                      ram_retain_o,     // RAM-keep mode
  output pdw_pkg::pdw_ctrl_type     domain_o,         // Domain controls
  output pdw_pkg::pdw_init_type     init_o,           // Entry init strobes
  output logic [SP_W-1:0]           sp_init_o,        // Stack init value
  output logic                      restart_o,        // Restart strobe
  output logic [PC_W-1:0]           restart_pc_o,     // Restart address
  output logic                      powerdown_flag_o, // Warm start flag
  output logic                      skip_o,           // Skip next instr
  output logic                      wake_by_timer_o,  // Timer wake seen
  output logic                      timer_pin_out_o,  // Timer pin level
  output logic                      timer_pin_oe_o    // Timer pin enable
);

  typedef struct packed
  {
    pdw_state_type   fsm;
    logic            armed;
    logic            pd_flag;
    logic            vdrop_stby;
    logic            skip;
    logic            restart;
    logic            wake_timer;
    pdw_ctrl_type    dom;
    pdw_init_type    init;
    logic            pin_out;
    logic            pin_oe;
    logic            pd_mode;
    logic            ram_mode;
  } pdw_core_state_type;

  pdw_core_state_type st_reg;
  pdw_core_state_type st_next;

  logic ext_wake_sync;
  logic vdrop_en_sync;
  logic pin_out_c;
  logic pin_oe_c;
  logic is_halt;
  logic is_clk_halt;
  logic is_ram_halt;
  logic sys_rst_instr;
  logic any_reset;
  logic pd_state;

  function automatic logic instr_is(input logic v, input logic [INSTR_W-1:0] c,
                                    input logic [INSTR_W-1:0] ref_c);
    instr_is = v && (c == ref_c);
  endfunction

  pdw_sync #(
    .RST_VAL (1'b0)
  ) i_pdw_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .clk_en_i   (clk_en_i),
    .async_i    (ext_wake_i),
    .sync_o     (ext_wake_sync)
  );

  // Detector enable is a pin as well
  pdw_sync #(
    .RST_VAL (1'b0)
  ) i_pdw_sync_vdrop (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .clk_en_i   (clk_en_i),
    .async_i    (vdrop_pin_en_i),
    .sync_o     (vdrop_en_sync)
  );

  assign pd_state = (st_reg.fsm == PDW_CLK_KEEP) || (st_reg.fsm == PDW_RAM_KEEP);

  pdw_pin_ctrl i_pdw_pin_ctrl (
    .powered_down_i (pd_state),
    .cnt_in_sel_i   (cnt_in_sel_i),
    .run_out_i      (tmr_pin_out_i),
    .run_oe_i       (tmr_pin_oe_i),
    .pin_out_o      (pin_out_c),
    .pin_oe_o       (pin_oe_c)
  );

  always_comb
  begin
    is_clk_halt   = instr_is(instr_valid_i, instr_code_i, INSTR_CLK_HALT);
    is_ram_halt   = instr_is(instr_valid_i, instr_code_i, INSTR_RAM_HALT);
    is_halt       = is_clk_halt || is_ram_halt;
    sys_rst_instr = instr_is(instr_valid_i, instr_code_i, INSTR_SYS_RST);
    any_reset     = sys_rst_instr || wdt_reset_i || por_reset_i || vdrop_reset_i;
  end

  always_comb
  begin
    st_next         = st_reg;
    st_next.init    = '0;
    st_next.restart = 1'b0;
    st_next.skip    = 1'b0;
    st_next.pin_out = pin_out_c;
    st_next.pin_oe  = pin_oe_c;
    case (st_reg.fsm)
      PDW_RUN:
      begin
        if (instr_valid_i)
        begin
          if (instr_code_i == INSTR_ARM)
          begin
            st_next.armed = 1'b1;
          end
          else
          begin
            st_next.armed = 1'b0;
          end
          if (instr_code_i == INSTR_VDROP_STBY)
          begin
            st_next.vdrop_stby = 1'b1;
          end
          if (instr_code_i == INSTR_SKIP_PDF)
          begin
            st_next.skip = st_reg.pd_flag;
          end
        end
        if (st_reg.armed && is_halt)
        begin
          st_next.fsm = is_clk_halt ? PDW_CLK_KEEP : PDW_RAM_KEEP;
          st_next.armed = 1'b0;
          st_next.init = '1;
          st_next.wake_timer = 1'b0;
          st_next.dom.sub_osc_run    = is_clk_halt;
          st_next.dom.lowspd_osc_run = is_clk_halt;
          st_next.dom.timer3_run     = is_clk_halt;
          st_next.dom.display_on     = is_clk_halt;
          st_next.dom.main_osc_run   = 1'b0;
          st_next.dom.timer1_2_valid = 1'b0;
          st_next.dom.timer_lc_valid = is_clk_halt;
          st_next.dom.vdrop_det_en   = vdrop_en_sync && st_reg.vdrop_stby;
        end
        else
        begin
          st_next.dom.vdrop_det_en = vdrop_en_sync;
        end
      end
      PDW_CLK_KEEP:
      begin
        if (ext_wake_sync || timer3_irq_flag_i)
        begin
          st_next.fsm = PDW_WAKE;
          st_next.wake_timer = timer3_irq_flag_i && !ext_wake_sync;
        end
      end
      PDW_RAM_KEEP:
      begin
        if (ext_wake_sync)
        begin
          st_next.fsm = PDW_WAKE;
        end
      end
      PDW_WAKE:
      begin
        st_next.fsm     = PDW_RUN;
        st_next.restart = 1'b1;
        st_next.pd_flag = 1'b1;
        st_next.dom     = '{sub_osc_run: 1'b1, lowspd_osc_run: 1'b1, main_osc_run: 1'b1,
                            timer3_run: 1'b1, display_on: 1'b1, timer1_2_valid: 1'b1,
                            timer_lc_valid: 1'b1, vdrop_det_en: vdrop_en_sync};
      end
      default:
      begin
        st_next.fsm = PDW_RUN;
      end
    endcase
    if (any_reset)
    begin
      st_next.fsm        = PDW_RUN;
      st_next.armed      = 1'b0;
      st_next.pd_flag    = 1'b0;
      st_next.vdrop_stby = 1'b0;
      st_next.restart    = 1'b1;
      st_next.dom        = '1;
    end
    // Mode flags follow the next state so the outputs come from flops
    st_next.pd_mode  = (st_next.fsm == PDW_CLK_KEEP) || (st_next.fsm == PDW_RAM_KEEP);
    st_next.ram_mode = (st_next.fsm == PDW_RAM_KEEP);
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_reg         <= '0;
      st_reg.fsm     <= PDW_RUN;
      st_reg.dom     <= '1;
      st_reg.restart <= 1'b1;
    end
    else if (clk_en_i)
    begin
      st_reg <= st_next;
    end
  end

  assign powered_down_o   = st_reg.pd_mode;
  assign ram_retain_o     = st_reg.ram_mode;
  // Retained state is simply never touched by the init strobes
  assign domain_o         = st_reg.dom;
  assign init_o           = st_reg.init;
  assign sp_init_o        = SP_INIT;
  assign restart_o        = st_reg.restart;
  assign restart_pc_o     = PC_START;
  assign powerdown_flag_o = st_reg.pd_flag;
  assign skip_o           = st_reg.skip;
  assign wake_by_timer_o  = st_reg.wake_timer;
  assign timer_pin_out_o  = st_reg.pin_out;
  assign timer_pin_oe_o   = st_reg.pin_oe;

  property p_arm_clk_entry;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && st_reg.fsm == PDW_RUN && st_reg.armed && is_clk_halt && !any_reset)
      |=> (st_reg.fsm == PDW_CLK_KEEP && st_reg.dom.display_on);
  endproperty
  a_arm_clk_entry: assert property (p_arm_clk_entry) else $error("Clock-keep entry missed");

  property p_halt_noarm;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && st_reg.fsm == PDW_RUN && !st_reg.armed) |=> st_reg.fsm == PDW_RUN;
  endproperty
  a_halt_noarm: assert property (p_halt_noarm) else $error("Entered power-down unarmed");

  property p_arm_clear;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && instr_valid_i && instr_code_i != INSTR_ARM && !is_halt) |=> !st_reg.armed;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("Arm not cleared");

  property p_ram_osc_off;
    @(posedge core_clk_i) disable iff (!nrst_i)
      st_reg.fsm == PDW_RAM_KEEP |-> !(st_reg.dom.sub_osc_run || st_reg.dom.display_on ||
                                       st_reg.dom.lowspd_osc_run || st_reg.dom.main_osc_run);
  endproperty
  a_ram_osc_off: assert property (p_ram_osc_off) else $error("Oscillation in RAM-keep");

  property p_entry_init;
    @(posedge core_clk_i) disable iff (!nrst_i)
      $rose(powered_down_o) |-> (init_o.watchdog && init_o.core_regs);
  endproperty
  a_entry_init: assert property (p_entry_init) else $error("No init on entry");

  property p_pin_low;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && pd_state && cnt_in_sel_i != SEL_CNTR_IN) |=>
        (timer_pin_oe_o && !timer_pin_out_o);
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("Timer pin not low");

  property p_ram_no_timer_wake;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && st_reg.fsm == PDW_RAM_KEEP && !ext_wake_sync && !any_reset)
      |=> st_reg.fsm == PDW_RAM_KEEP;
  endproperty
  a_ram_no_timer_wake: assert property (p_ram_no_timer_wake) else $error("RAM-keep left");

  property p_warm_start;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && st_reg.fsm == PDW_WAKE && !any_reset) |=> (restart_o && powerdown_flag_o);
  endproperty
  a_warm_start: assert property (p_warm_start) else $error("Warm start wrong");

  property p_cold_start;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && any_reset) |=> (!powerdown_flag_o && restart_o && !powered_down_o);
  endproperty
  a_cold_start: assert property (p_cold_start) else $error("Cold start wrong");

  property p_vdrop_standby;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && st_reg.fsm == PDW_RUN && st_reg.armed && is_halt && !any_reset &&
       !st_reg.vdrop_stby) |=> !domain_o.vdrop_det_en;
  endproperty
  a_vdrop_standby: assert property (p_vdrop_standby) else $error("Detector left on");

  property p_skip_flag;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && st_reg.fsm == PDW_RUN && instr_valid_i && instr_code_i == INSTR_SKIP_PDF &&
       !any_reset) |=> (skip_o == $past(powerdown_flag_o));
  endproperty
  a_skip_flag: assert property (p_skip_flag) else $error("Skip does not follow flag");

  property p_timer_wake;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && st_reg.fsm == PDW_CLK_KEEP && timer3_irq_flag_i && !ext_wake_sync &&
       !any_reset) |=> (st_reg.fsm == PDW_WAKE && wake_by_timer_o);
  endproperty
  a_timer_wake: assert property (p_timer_wake) else $error("Timer wake missed");

  property p_timer_lc_ram;
    @(posedge core_clk_i) disable iff (!nrst_i)
      ram_retain_o |-> !(domain_o.timer_lc_valid || domain_o.timer1_2_valid);
  endproperty
  a_timer_lc_ram: assert property (p_timer_lc_ram) else $error("Timers valid in RAM-keep");

endmodule

// ===== testbench/test_power_down_wake_controller.sv
/*
  Self-checking bench for the power-down wake controller: arming, both
  low-power modes, domain controls, timer pin, warm and cold starts.
  Assumes pdw_ctrl with the package codes; clk_en_i low only when freezing.
*/
`timescale 1ns/10ps
module test_power_down_wake_controller;
  import pdw_pkg::*;

  logic               core_clk_i;
  logic               nrst_i;
  logic               clk_en;
  logic               instr_valid;
  logic [INSTR_W-1:0] instr_code;
  logic               ext_wake;
  logic               t3_flag;
  logic               vdrop_en;
  logic               wdt_rst;
  logic               por_rst;
  logic               vdrop_rst;
  logic [1:0]         cnt_sel;
  logic               pin_out;
  logic               pin_oe;
  logic               pd;
  logic               ram_ret;
  pdw_ctrl_type       dom;
  pdw_init_type       init;
  logic [SP_W-1:0]    sp;
  logic               restart;
  logic [PC_W-1:0]    rpc;
  logic               pd_flag;
  logic               skip;
  logic               by_timer;
  logic               tp_out;
  logic               tp_oe;
  int                 num_errors;
  int                 compares;
  int                 cycles;

  pdw_ctrl i_pdw_ctrl (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en),
    .instr_valid_i(instr_valid), .instr_code_i(instr_code), .ext_wake_i(ext_wake),
    .timer3_irq_flag_i(t3_flag), .vdrop_pin_en_i(vdrop_en), .wdt_reset_i(wdt_rst),
    .por_reset_i(por_rst), .vdrop_reset_i(vdrop_rst), .cnt_in_sel_i(cnt_sel),
    .tmr_pin_out_i(pin_out), .tmr_pin_oe_i(pin_oe), .powered_down_o(pd),
    .ram_retain_o(ram_ret), .domain_o(dom), .init_o(init), .sp_init_o(sp),
    .restart_o(restart), .restart_pc_o(rpc), .powerdown_flag_o(pd_flag),
    .skip_o(skip), .wake_by_timer_o(by_timer), .timer_pin_out_o(tp_out),
    .timer_pin_oe_o(tp_oe)
  );

  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      num_errors++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // Valid stays up across back-to-back calls
  task automatic instr(input logic [INSTR_W-1:0] code);
    instr_valid = 1'b1;
    instr_code  = code;
    tick(1);
  endtask

  task automatic enter(input logic [INSTR_W-1:0] halt);
    instr(INSTR_WDT_RST);
    instr(INSTR_ARM);
    instr(halt);
    instr_valid = 1'b0;
    check("powered_down", pd, 1'b1);
    check("init", init, 7'h7F);
    check("sp_init", sp, 3'h7);
    tick(1);
    check("init_end", init, 7'h00);
  endtask

  // Wake by timer flag or pin, bounded wait for the restart strobe
  task automatic wake(input logic use_timer);
    int n;
    if (use_timer)
      t3_flag = 1'b1;
    else
      ext_wake = 1'b1;
    for (n = 0; n < 20 && restart !== 1'b1; n++)
      tick(1);
    t3_flag  = 1'b0;
    ext_wake = 1'b0;
    check("restart", restart, 1'b1);
    check("restart_pc", rpc, 13'h0000);
    check("pd_flag_warm", pd_flag, 1'b1);
    check("wake_by_timer", by_timer, use_timer);
    check("run_after_wake", pd, 1'b0);
    // Let the wake synchroniser drain before the next entry
    tick(4);
  endtask

  // Frozen clock enable takes no instruction
  task automatic t_freeze;
    clk_en = 1'b0;
    instr(INSTR_ARM);
    instr(INSTR_CLK_HALT);
    instr_valid = 1'b0;
    tick(1);
    check("frozen", pd, 1'b0);
    clk_en = 1'b1;
    tick(1);
    check("frozen_flag", pd_flag, 1'b0);
  endtask

  task automatic t_no_arm;
    check("pd_flag_cold", pd_flag, 1'b0);
    instr(INSTR_CLK_HALT);
    instr(INSTR_RAM_HALT);
    instr(INSTR_ARM);
    instr(INSTR_NOP);
    instr(INSTR_CLK_HALT);
    instr_valid = 1'b0;
    tick(1);
    check("no_entry", pd, 1'b0);
  endtask

  task automatic t_clock_keep;
    vdrop_en = 1'b1;
    pin_out  = 1'b1;
    pin_oe   = 1'b1;
    tick(2);
    check("pin_run", {tp_out, tp_oe}, 2'b11);
    enter(INSTR_CLK_HALT);
    check("ram_retain", ram_ret, 1'b0);
    check("keep_doms", {dom.sub_osc_run, dom.lowspd_osc_run, dom.timer3_run,
      dom.display_on}, 4'hF);
    check("timers", {dom.timer1_2_valid, dom.timer_lc_valid}, 2'b01);
    check("vdrop_off", dom.vdrop_det_en, 1'b0);
    tick(1);
    check("pin_pd", {tp_out, tp_oe}, 2'b01);
    cnt_sel = SEL_CNTR_IN;
    tick(2);
    check("pin_hiz", tp_oe, 1'b0);
    cnt_sel = 2'b00;
    wake(1'b1);
    instr(INSTR_SKIP_PDF);
    instr_valid = 1'b0;
    check("skip_warm", skip, 1'b1);
  endtask

  task automatic t_ram_keep;
    tick(1);
    instr(INSTR_VDROP_STBY);
    enter(INSTR_RAM_HALT);
    check("ram_mode", ram_ret, 1'b1);
    check("ram_doms", {dom.sub_osc_run, dom.lowspd_osc_run, dom.main_osc_run,
      dom.timer3_run, dom.display_on, dom.timer1_2_valid, dom.timer_lc_valid},
      7'h00);
    check("vdrop_on", dom.vdrop_det_en, 1'b1);
    t3_flag = 1'b1;
    tick(10);
    t3_flag = 1'b0;
    check("t3_refused", pd, 1'b1);
    tick(1);
    wake(1'b0);
  endtask

  // Each reset source after a warm start
  task automatic t_cold;
    int k;
    for (k = 0; k < 4; k++)
    begin
      enter(INSTR_CLK_HALT);
      wake(1'b1);
      tick(1);
      if (k == 3)
        instr(INSTR_SYS_RST);
      else
      begin
        por_rst   = (k == 0);
        wdt_rst   = (k == 1);
        vdrop_rst = (k == 2);
        tick(1);
      end
      instr_valid = 1'b0;
      por_rst     = 1'b0;
      wdt_rst     = 1'b0;
      vdrop_rst   = 1'b0;
      check("cold_flag", pd_flag, 1'b0);
      check("cold_restart", restart, 1'b1);
      tick(1);
      instr(INSTR_SKIP_PDF);
      instr_valid = 1'b0;
      check("skip_cold", skip, 1'b0);
      tick(1);
    end
    enter(INSTR_CLK_HALT);
    check("vdrop_cleared", dom.vdrop_det_en, 1'b0);
    wake(1'b0);
  endtask

  initial
  begin
    nrst_i      = 1'b0;
    clk_en      = 1'b1;
    instr_valid = 1'b0;
    instr_code  = INSTR_NOP;
    ext_wake    = 1'b0;
    t3_flag     = 1'b0;
    vdrop_en    = 1'b0;
    wdt_rst     = 1'b0;
    por_rst     = 1'b0;
    vdrop_rst   = 1'b0;
    cnt_sel     = 2'b00;
    pin_out     = 1'b0;
    pin_oe      = 1'b0;
    num_errors  = 0;
    compares    = 0;
    cycles      = 0;
    tick(10);
    nrst_i = 1'b1;
    tick(2);
    t_no_arm();
    t_freeze();
    t_clock_keep();
    t_ram_keep();
    t_cold();
    summarize();
  end
endmodule
